// [src/dpi_sequencer.sv]
/*
 Host-side power-up and reset sequencer for a synchronous dynamic memory.
 Software starts it and loads mode words over APB; the block drives reset,
 clock gate, termination control, the gated memory clock and command pins.
 Assumes power is stable when resetn releases and a 20 MHz clock.
*/
// Contract
// - Hold memory reset low at least 200 us after power is stable.
// - Keep connectivity check enable low at least 700 us after power up.
// - Drive clock gate low at least 10 ns before releasing memory reset.
// - Wait at least 500 us after reset release before raising clock gate.
// - Run memory clock at least max(10 ns, five periods) before clock gate rises.
// - Present deselect on the edge where clock gate first rises.
// - Keep clock gate high every cycle until initialisation ends.
// - Termination control static from before clock gate high until done.
// - Hold termination control low when nominal termination is enabled; code drives the CTRL term bit as written, mode words unchecked.
// - Wait reset exit time, max(refresh exit, five clocks), before first load.
// - Load mode registers in order three, six, five, four, two, one, zero.
// - Drive group and bank select bits as the binary register number.
// - Issue long impedance calibration after the last mode load.
// - Wait both lock time and calibration time before signalling ready.
// - Every other cycle from clock gate high to calibration carries deselect.
// - Load every mode register that has defined settings.
// - Stable-power reset holds reset the minimum pulse, gate low beforehand.
// - After stable-power reset repeat the sequence from the post-reset wait.
// - Gear-down, addressability, latencies and repair default off at reset.
// - Commands decode on rising edge; chip select high means deselect.
`timescale 1ns/1ps
module dpi_sequencer
   import dpi_pkg::*;
#(
   parameter int RESET_HOLD    = dpi_pkg::RESET_HOLD_CYC,
   parameter int CONN_CHECK    = dpi_pkg::CONN_CHECK_CYC,
   parameter int POST_RESET    = dpi_pkg::POST_RESET_CYC,
   parameter int RESET_PULSE   = dpi_pkg::RESET_PULSE_CYC
) (
   input  wire logic               clk,
   input  wire logic               resetn,
   input  wire logic [11:0]        paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   output logic                    mem_reset_n,
   output logic                    clk_gate,
   output logic                    termination_ctrl_in,
   output logic                    connectivity_check_enable,
   output logic                    mem_clk,
   output dpi_pkg::dpi_cmd_type    cmd,
   output logic                    init_done
);
   import dpi_pkg::*;

   typedef struct packed {
      dpi_state_type  state;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] conn_cnt;
      logic           powered;
      logic           start;
      logic           term_high;
      logic [2:0]     step;
      logic           mem_reset_n;
      logic           clk_gate;
      logic           clk_run;
      logic           clk_ph;
      logic           term;
      logic           conn_en;
      dpi_cmd_type    cmd;
      logic           done;
      logic [31:0]    prdata;
   } dpi_regs_type;

   dpi_regs_type r;
   dpi_regs_type next_r;

   logic             apb_wr;
   logic             apb_rd;
   logic             mem_wr;
   logic [16:0]      mode_word;
   logic [2:0]       mode_num;
   logic [2:0]       mode_next;
   logic [11:0]      mode_off;

   // ------------------------------------------------------------------------
   // APB slave: zero wait states, error on unmapped addresses.
   // ------------------------------------------------------------------------
   function automatic logic mapped(input logic [11:0] a);
      return (a == CTRL_OFFSET) || (a == STATUS_OFFSET) ||
             ((a >= MODE_BASE) && (a < MODE_BASE + 12'(MODE_REGS * 4)) && (a[1:0] == 2'h0));
   endfunction

   assign apb_wr   = psel && penable && pwrite;
   assign apb_rd   = psel && !penable && !pwrite;
   assign mode_off = paddr - MODE_BASE;
   assign mem_wr   = apb_wr && mapped(paddr) && (paddr >= MODE_BASE);
   assign mode_num = mode_order(r.step);
   // The store's read data lag its address by a cycle, so it is addressed with the step to come.
   assign mode_next = mode_order(next_r.step);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped(paddr);

   dpi_mode_mem #(
      .WIDTH (17),
      .DEPTH (MODE_REGS)
   ) u_mode_mem (
      .clk     (clk),
      .resetn  (resetn),
      .wr_en   (mem_wr),
      .wr_addr (mode_off[4:2]),
      .wr_data (pwdata[16:0]),
      .rd_addr (mode_next),
      .rd_data (mode_word)
   );

   // ------------------------------------------------------------------------
   // Sequencer.
   // ------------------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.cmd.cs_n = 1'b1;
      next_r.cmd.row_open_n = 1'b1;
      next_r.cmd.ras_n = 1'b1;
      next_r.cmd.cas_n = 1'b1;
      next_r.cmd.we_n = 1'b1;
      if (r.cnt != '0) begin
         next_r.cnt = r.cnt - 1'b1;
      end
      if (r.conn_cnt != '0) begin
         next_r.conn_cnt = r.conn_cnt - 1'b1;
      end
      // Connectivity check enable never rises in this block; normal use wants it low.
      next_r.conn_en = 1'b0;
      if (r.clk_run) begin
         next_r.clk_ph = !r.clk_ph;
      end

      if (apb_wr && (paddr == CTRL_OFFSET)) begin
         // Start and level are taken only while idle or done, so a start written
         // mid-sequence cannot restart it and the termination level stays static.
         if ((r.state == ST_IDLE) || (r.state == ST_DONE)) begin
            next_r.start = pwdata[CTRL_START_BIT];
            next_r.term_high = pwdata[CTRL_TERM_BIT];
         end
      end
      next_r.prdata = 32'h0000_0000;
      if (apb_rd && (paddr == STATUS_OFFSET)) begin
         next_r.prdata[STAT_DONE_BIT] = r.done;
         next_r.prdata[STAT_BUSY_BIT] = (r.state != ST_IDLE) && (r.state != ST_DONE);
         next_r.prdata[STAT_STATE_LSB +: 4] = r.state;
      end else if (apb_rd && (paddr == CTRL_OFFSET)) begin
         next_r.prdata[CTRL_START_BIT] = r.start;
         next_r.prdata[CTRL_TERM_BIT] = r.term_high;
      end

      case (r.state)
         ST_IDLE: begin
            next_r.mem_reset_n = 1'b0;
            next_r.clk_gate = 1'b0;
            next_r.done = 1'b0;
            if (r.start) begin
               next_r.start = 1'b0;
               next_r.state = ST_RESET_HOLD;
               // First pass after power needs the long hold, later passes the pulse.
               next_r.cnt = r.powered ? CNT_W'(RESET_PULSE) : CNT_W'(RESET_HOLD);
            end
         end
         ST_RESET_HOLD: begin
            next_r.clk_gate = 1'b0;
            if (r.cnt == '0) begin
               next_r.state = ST_GATE_LEAD;
               next_r.cnt = CNT_W'(GATE_LEAD_CYC);
            end
         end
         ST_GATE_LEAD: begin
            if (r.cnt == '0) begin
               next_r.mem_reset_n = 1'b1;
               next_r.powered = 1'b1;
               next_r.state = ST_POST_RESET;
               next_r.cnt = CNT_W'(POST_RESET);
            end
         end
         ST_POST_RESET: begin
            // The memory clock is held still here; the part does not need it.
            if (r.cnt == '0) begin
               next_r.clk_run = 1'b1;
               next_r.state = ST_CLK_STABLE;
               next_r.cnt = CNT_W'(2 * CLK_STABLE_CYC);
               next_r.term = r.term_high;
            end
         end
         ST_CLK_STABLE: begin
            if ((r.cnt == '0) && r.clk_ph && (r.conn_cnt == '0)) begin
               next_r.clk_gate = 1'b1;
               next_r.state = ST_RESET_EXIT;
               next_r.cnt = CNT_W'(2 * RESET_EXIT_CYC);
            end
         end
         ST_RESET_EXIT: begin
            if (r.cnt == '0) begin
               next_r.state = ST_MODE_LOAD;
               next_r.step = 3'h0;
            end
         end
         ST_MODE_LOAD: begin
            if (r.clk_ph) begin
               next_r.cmd.cs_n = CMD_MODE_LOAD[4];
               next_r.cmd.row_open_n = CMD_MODE_LOAD[3];
               next_r.cmd.ras_n = CMD_MODE_LOAD[2];
               next_r.cmd.cas_n = CMD_MODE_LOAD[1];
               next_r.cmd.we_n = CMD_MODE_LOAD[0];
               next_r.cmd.group_sel_bit = mode_num[2];
               next_r.cmd.bank_sel_hi = mode_num[1];
               next_r.cmd.bank_sel_lo = mode_num[0];
               next_r.cmd.addr = mode_word | MODE_RESET;
               next_r.state = ST_MODE_GAP;
               next_r.cnt = CNT_W'(2 * MODE_LOAD_GAP_NCK);
            end
         end
         ST_MODE_GAP: begin
            if (r.cnt == '0) begin
               if (r.step == 3'(MODE_REGS - 1)) begin
                  next_r.state = ST_LONG_CAL;
               end else begin
                  next_r.step = r.step + 3'h1;
                  next_r.state = ST_MODE_LOAD;
               end
            end
         end
         ST_LONG_CAL: begin
            if (r.clk_ph) begin
               next_r.cmd.cs_n = CMD_LONG_CAL[4];
               next_r.cmd.row_open_n = CMD_LONG_CAL[3];
               next_r.cmd.ras_n = CMD_LONG_CAL[2];
               next_r.cmd.cas_n = CMD_LONG_CAL[1];
               next_r.cmd.we_n = CMD_LONG_CAL[0];
               next_r.cmd.addr = 17'h0_0000;
               next_r.cmd.addr[LONG_CAL_BIT] = 1'b1;
               next_r.state = ST_READY_WAIT;
               next_r.cnt = CNT_W'(2 * READY_WAIT_CYC);
            end
         end
         ST_READY_WAIT: begin
            if (r.cnt == '0) begin
               next_r.state = ST_DONE;
               next_r.done = 1'b1;
            end
         end
         ST_DONE: begin
            if (r.start) begin
               next_r.start = 1'b0;
               next_r.done = 1'b0;
               next_r.mem_reset_n = 1'b0;
               next_r.clk_gate = 1'b0;
               next_r.clk_run = 1'b0;
               next_r.clk_ph = 1'b0;
               next_r.state = ST_RESET_HOLD;
               next_r.cnt = CNT_W'(RESET_PULSE);
            end
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase
   end

   // Clock gate stays high from its first rise until a new reset pass.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '{state: ST_IDLE, cnt: '0, conn_cnt: CNT_W'(CONN_CHECK),
                powered: 1'b0, start: 1'b0, term_high: 1'b0, step: 3'h0,
                mem_reset_n: 1'b0, clk_gate: 1'b0, clk_run: 1'b0, clk_ph: 1'b0,
                term: 1'b0, conn_en: 1'b0,
                cmd: '{cs_n: 1'b1, row_open_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                       we_n: 1'b1, group_sel_bit: 1'b0, bank_sel_hi: 1'b0,
                       bank_sel_lo: 1'b0, addr: 17'h0_0000},
                done: 1'b0, prdata: 32'h0000_0000};
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------------------
   // Outputs. The memory clock is clk divided by two; commands change on its
   // falling half so each is stable a full system period before its rise.
   // ------------------------------------------------------------------------
   assign mem_reset_n               = r.mem_reset_n;
   assign clk_gate                  = r.clk_gate;
   assign termination_ctrl_in       = r.term;
   assign connectivity_check_enable = r.conn_en;
   assign mem_clk                   = r.clk_ph;
   assign cmd                       = r.cmd;
   assign init_done                 = r.done;
   assign prdata                    = r.prdata;
endmodule // dpi_sequencer

// [src/dpi_pkg.sv]
/*
 Package of the memory power-up sequencer: APB register map, field positions,
 reset values, timing figures with derived cycle counts, command encodings and
 the state type.
 Assumes a 20 MHz system clock.
*/
package dpi_pkg;

   // ------------------------------------------------------------------------
   // Clock and timing.
   // ------------------------------------------------------------------------
   localparam int CLK_PERIOD_PS          = 50000;
   localparam int RESET_HOLD_US          = 200;
   localparam int CONN_CHECK_LOW_US      = 700;
   localparam int GATE_LOW_LEAD_NS       = 10;
   localparam int POST_RESET_WAIT_US     = 500;
   localparam int CLK_STABLE_NS          = 10;
   localparam int CLK_STABLE_NCK         = 5;
   localparam int REFRESH_EXIT_TIME_NS   = 170;
   localparam int RESET_EXIT_NCK         = 5;
   localparam int RESET_PULSE_MIN_NS     = 1000;
   localparam int DELAY_LOOP_LOCK_NCK    = 1024;
   localparam int IMPEDANCE_INIT_NCK     = 1024;
   localparam int MODE_LOAD_GAP_NCK      = 24;

   function automatic int ns_cycles(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int RESET_HOLD_CYC    = ns_cycles(RESET_HOLD_US * 1000);
   localparam int CONN_CHECK_CYC    = ns_cycles(CONN_CHECK_LOW_US * 1000);
   localparam int GATE_LEAD_CYC     = ns_cycles(GATE_LOW_LEAD_NS);
   localparam int POST_RESET_CYC    = ns_cycles(POST_RESET_WAIT_US * 1000);
   localparam int CLK_STABLE_CYC    = (ns_cycles(CLK_STABLE_NS) > CLK_STABLE_NCK) ?
                                      ns_cycles(CLK_STABLE_NS) : CLK_STABLE_NCK;
   localparam int RESET_EXIT_CYC    = (ns_cycles(REFRESH_EXIT_TIME_NS) > RESET_EXIT_NCK) ?
                                      ns_cycles(REFRESH_EXIT_TIME_NS) : RESET_EXIT_NCK;
   localparam int RESET_PULSE_CYC   = ns_cycles(RESET_PULSE_MIN_NS);
   localparam int READY_WAIT_CYC    = (DELAY_LOOP_LOCK_NCK > IMPEDANCE_INIT_NCK) ?
                                      DELAY_LOOP_LOCK_NCK : IMPEDANCE_INIT_NCK;
   localparam int CNT_W             = 20;

   // ------------------------------------------------------------------------
   // Register map, one 32-bit word each.
   // ------------------------------------------------------------------------
   localparam logic [11:0] CTRL_OFFSET    = 12'h000;
   localparam logic [11:0] STATUS_OFFSET  = 12'h004;
   localparam logic [11:0] MODE_BASE      = 12'h010;
   localparam int          CTRL_START_BIT = 0;
   localparam int          CTRL_TERM_BIT  = 1;
   localparam int          STAT_DONE_BIT  = 0;
   localparam int          STAT_BUSY_BIT  = 1;
   localparam int          STAT_STATE_LSB = 4;
   localparam int          MODE_REGS      = 7;
   localparam logic [16:0] MODE_RESET     = 17'h0_0000;

   // ------------------------------------------------------------------------
   // Command pins: cs_n, row_open_n, ras_n, cas_n, we_n.
   // ------------------------------------------------------------------------
   localparam logic [4:0] CMD_DESELECT  = 5'h1F;
   localparam logic [4:0] CMD_MODE_LOAD = 5'h08;
   localparam logic [4:0] CMD_LONG_CAL  = 5'h0E;
   localparam int         LONG_CAL_BIT  = 10;

   typedef struct packed {
      logic        cs_n;
      logic        row_open_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic        group_sel_bit;
      logic        bank_sel_hi;
      logic        bank_sel_lo;
      logic [16:0] addr;
   } dpi_cmd_type;

   typedef enum logic [3:0] {
      ST_IDLE, ST_RESET_HOLD, ST_GATE_LEAD, ST_POST_RESET, ST_CLK_STABLE,
      ST_RESET_EXIT, ST_MODE_LOAD, ST_MODE_GAP, ST_LONG_CAL, ST_READY_WAIT, ST_DONE
   } dpi_state_type;

   // Mode register issue order, as register numbers.
   function automatic logic [2:0] mode_order(input logic [2:0] step);
      case (step)
         3'h0:    return 3'h3;
         3'h1:    return 3'h6;
         3'h2:    return 3'h5;
         3'h3:    return 3'h4;
         3'h4:    return 3'h2;
         3'h5:    return 3'h1;
         default: return 3'h0;
      endcase
   endfunction

endpackage

// [src/dpi_mode_mem.sv]
/*
 Small store for the seven mode register words written by software.
 Assumes one clock; read data comes from a register one cycle after the address.
*/
`timescale 1ns/1ps
module dpi_mode_mem #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 7
) (
   input  wire logic                     clk,
   input  wire logic                     resetn,
   input  wire logic                     wr_en,
   input  wire logic [2:0]               wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [2:0]               rd_addr,
   output logic      [WIDTH-1:0]         rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // ------------------------------------------------------------------------
   // Storage. Contents clear at reset so a skipped write loads defaults off.
   // ------------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
         rd_data <= '0;
      end else begin
         if (wr_en && (int'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
      end
   end
endmodule // dpi_mode_mem

// [tb/dpi_sequencer_chk.sv]
/*
 Checker of the sequencer's memory-side pins, bound into dpi_sequencer.
 Assumes one system clock and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module dpi_sequencer_chk #(
   parameter int POST_RESET = 20
) (
   input wire logic                 clk,
   input wire logic                 resetn,
   input wire logic                 mem_reset_n,
   input wire logic                 clk_gate,
   input wire logic                 termination_ctrl_in,
   input wire logic                 connectivity_check_enable,
   input wire logic                 mem_clk,
   input wire dpi_pkg::dpi_cmd_type cmd,
   input wire logic                 init_done
);
   import dpi_pkg::*;
   // ----------------------------------------------------------------
   // Age counters; each restarts when its cause goes away.
   // ----------------------------------------------------------------
   localparam logic [20:0] ORD = 21'h0F_5888;
   int         rst_age;
   int         tog;
   int         gate_age;
   int         cal_age;
   int         idx;
   logic       mclk_q;
   logic [4:0] op;
   logic       is_load;
   logic       is_cal;
   assign op = cmd[24:20];
   assign is_load = op == CMD_MODE_LOAD;
   assign is_cal = op == CMD_LONG_CAL;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_age <= 0;
         tog <= 0;
         gate_age <= 0;
         cal_age <= 0;
         idx <= 0;
         mclk_q <= 1'b0;
      end else begin
         mclk_q <= mem_clk;
         rst_age <= mem_reset_n ? rst_age + 1 : 0;
         tog <= mem_reset_n ? tog + int'(mem_clk != mclk_q) : 0;
         gate_age <= clk_gate ? gate_age + 1 : 0;
         cal_age <= !clk_gate ? 0 : (is_cal ? 1 : cal_age + 1);
         idx <= clk_gate ? idx + int'(is_load) : 0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_conn_low: assert property (connectivity_check_enable == 1'b0)
      else $error("connectivity enable went high");
   chk_gate_lead: assert property ($rose(mem_reset_n) |-> !clk_gate && !$past(clk_gate))
      else $error("clock gate not low before reset release");
   chk_post_wait: assert property ($rose(clk_gate) |-> rst_age >= POST_RESET)
      else $error("clock gate rose too soon after reset release");
   chk_clk_run: assert property ($rose(clk_gate) |-> tog >= 10)
      else $error("memory clock ran under five periods before gate");
   chk_gate_des: assert property ($rose(clk_gate) |-> cmd.cs_n)
      else $error("no deselect when gate rose");
   chk_cmd_gated: assert property (!cmd.cs_n |-> clk_gate && mem_reset_n)
      else $error("command issued without gate high");
   chk_term_static: assert property (clk_gate && !init_done |-> $stable(termination_ctrl_in))
      else $error("termination control moved during init");
   chk_exit_wait: assert property (!cmd.cs_n |-> gate_age >= 10)
      else $error("command before reset exit wait");
   chk_mode_order: assert property (is_load |-> idx < 7 && {cmd.group_sel_bit,
      cmd.bank_sel_hi, cmd.bank_sel_lo} == 3'(ORD >> (18 - 3 * idx)))
      else $error("mode load out of order");
   chk_cmd_legal: assert property (!cmd.cs_n |-> is_load
      || (is_cal && cmd.addr[10] && idx == 7))
      else $error("illegal command during init");
   chk_ready_wait: assert property ($rose(init_done) |-> cal_age >= 2048)
      else $error("done before lock and calibration time");
   cov_gate: cover property ($rose(clk_gate));
   cov_load: cover property (is_load);
   cov_done: cover property ($rose(init_done));
endmodule // dpi_sequencer_chk

bind dpi_sequencer dpi_sequencer_chk #(.POST_RESET(POST_RESET)) chk_i (.clk, .resetn,
   .mem_reset_n, .clk_gate, .termination_ctrl_in, .connectivity_check_enable, .mem_clk,
   .cmd, .init_done);

// [tb/dpi_mem_model.sv]
/*
 Behavioural memory device that records the loads and calibration it sees.
 Assumes commands are taken on the system clock while the gate is high.
*/
`timescale 1ns/1ps
module dpi_mem_model (
   input wire logic                 clk,
   input wire logic                 mem_reset_n,
   input wire logic                 clk_gate,
   input wire dpi_pkg::dpi_cmd_type cmd,
   output logic                     term_hiz,
   output logic [3:0]               loads,
   output logic [20:0]              seq,
   output logic                     cal_seen,
   output logic [6:0][16:0]         mr
);
   import dpi_pkg::*;
   // ----------------------------------------------------------------
   // Command decode.
   // ----------------------------------------------------------------
   logic       gate_seen;
   logic [4:0] op;
   assign op = cmd[24:20];
   assign term_hiz = !mem_reset_n || !gate_seen;
   // Start-up needs only the reset level and the clock gate, never memory clock edges.
   always_ff @(posedge clk or negedge mem_reset_n) begin
      if (!mem_reset_n) begin
         gate_seen <= 1'b0;
         loads <= 4'h0;
         seq <= 21'h00_0000;
         cal_seen <= 1'b0;
         mr <= '0;
      end else if (clk_gate) begin
         gate_seen <= 1'b1;
         if (op == CMD_MODE_LOAD) begin
            loads <= loads + 4'h1;
            seq <= {seq[17:0], cmd.group_sel_bit, cmd.bank_sel_hi, cmd.bank_sel_lo};
            mr[{cmd.group_sel_bit, cmd.bank_sel_hi, cmd.bank_sel_lo}] <= cmd.addr;
         end
         if (op == CMD_LONG_CAL && cmd.addr[10]) cal_seen <= 1'b1;
      end
   end
endmodule // dpi_mem_model

// [tb/dpi_sequencer_bench.sv]
/*
 Self-checking bench of the sequencer: APB table, three full passes, mid-run reset.
 Assumes the design's zero-wait APB slave and shortened waits.
*/
`timescale 1ns/1ps
module dpi_sequencer_bench;
   import dpi_pkg::*;
   typedef struct packed {
      logic [11:0] a;
      logic        w;
      logic [31:0] d;
      logic [31:0] x;
      logic        e;
   } dpi_row_type;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, e;
   logic mem_reset_n, clk_gate, termination_ctrl_in, connectivity_check_enable;
   logic mem_clk, init_done, term_hiz, cal_seen;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata, r;
   logic [3:0]       loads;
   logic [20:0]      seq;
   logic [6:0][16:0] mr;
   dpi_cmd_type      cmd;
   dpi_row_type      rows [5];
   int               mismatches, samples_checked;
   dpi_sequencer #(.RESET_HOLD(20), .CONN_CHECK(30), .POST_RESET(20), .RESET_PULSE(5)) DUT (
      .clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .mem_reset_n, .clk_gate, .termination_ctrl_in, .connectivity_check_enable, .mem_clk,
      .cmd, .init_done);
   dpi_mem_model mem_i (.clk, .mem_reset_n, .clk_gate, .cmd, .term_hiz, .loads, .seq,
      .cal_seen, .mr);
   // ----------------------------------------------------------------
   // Tasks.
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [31:0] word(input int n);
      return 32'h0000_A000 + 32'(n) * 32'h0000_0111;
   endfunction
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic load_words;
      for (int n = 0; n < 7; n++) apb(MODE_BASE + 12'(4 * n), 1'b1, word(n));
   endtask
   task automatic run_pass(input int hold);
      int lows;
      lows = 0;
      apb(CTRL_OFFSET, 1'b1, 32'h0000_0003);
      repeat (40) begin
         @(posedge clk);
         if (mem_reset_n === 1'b0) lows++;
      end
      chk("reset low cycles", 32'(hold + GATE_LEAD_CYC + 2), 32'(lows));
      chk("term hiz early", 32'h0000_0001, 32'(term_hiz));
      apb(STATUS_OFFSET, 1'b0, 32'h0000_0000);
      chk("busy", 32'h0000_0002, r & 32'h0000_0003);
      apb(CTRL_OFFSET, 1'b1, 32'h0000_0003);
      for (int i = 0; i < 6000 && init_done !== 1'b1; i++) @(posedge clk);
      chk("done", 32'h0000_0001, 32'(init_done));
      chk("loads", 32'h0000_0007, 32'(loads));
      chk("order", 32'h000F_5888, 32'(seq));
      for (int n = 0; n < 7; n++) chk("mode word", word(n), 32'(mr[n]));
      chk("cal", 32'h0000_0001, 32'(cal_seen));
      chk("term hiz", 32'h0000_0000, 32'(term_hiz));
      chk("conn", 32'h0000_0000, 32'(connectivity_check_enable));
      chk("term", 32'h0000_0001, 32'(termination_ctrl_in));
      apb(STATUS_OFFSET, 1'b0, 32'h0000_0000);
      chk("status", 32'h0000_0001, r & 32'h0000_0003);
   endtask
   task automatic summarize;
      $display("Checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      summarize();
   end
   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      mismatches = 0;
      samples_checked = 0;
      rows = '{'{12'h004, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
               '{12'h010, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
               '{12'h100, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1},
               '{12'h02C, 1'b1, 32'h0000_0001, 32'h0000_0000, 1'b1},
               '{12'h000, 1'b1, 32'h0000_0002, 32'h0000_0000, 1'b0}};
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk("idle done", 32'h0000_0000, 32'(init_done));
      load_words();
      foreach (rows[k]) begin
         apb(rows[k].a, rows[k].w, rows[k].d);
         chk("pslverr", 32'(rows[k].e), 32'(e));
         if (!rows[k].w) chk("prdata", rows[k].x, r);
      end
      run_pass(20);
      run_pass(5);
      apb(CTRL_OFFSET, 1'b1, 32'h0000_0003);
      repeat (300) @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      chk("pins in reset", 32'h0000_0000, 32'({init_done, clk_gate, mem_reset_n}));
      resetn <= 1'b1;
      @(posedge clk);
      load_words();
      run_pass(20);
      summarize();
   end
endmodule // dpi_sequencer_bench
